// [design/uart_aux_pkg.sv]
// Constants and carrier types for the serial port auxiliary status and control block
package uart_aux_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 2;
    localparam logic [1:0] REG_AUX_STATUS = 2'h0;
    localparam logic [1:0] REG_AUX_CONTROL = 2'h1;
    localparam logic [7:0] RESET_VALUE = 8'h00;

    // Status register bit positions
    localparam int ST_BREAK_SEEN = 7;
    localparam int ST_RX_EDGE = 6;
    localparam int ST_RX_INV = 4;
    localparam int ST_IDLE_REPORT = 3;
    localparam int ST_LONG_BRK_TX = 2;
    localparam int ST_LONG_BRK_DET = 1;
    localparam int ST_RX_ACTIVE = 0;

    // Control register bit positions
    localparam int CT_RX_NINTH = 7;
    localparam int CT_TX_NINTH = 6;
    localparam int CT_TX_DIR = 5;
    localparam int CT_TX_INV = 4;
    localparam int CT_OVERRUN_IE = 3;
    localparam int CT_NOISE_IE = 2;
    localparam int CT_FRAME_IE = 1;
    localparam int CT_PARITY_IE = 0;

    // ------------------------------------------------------------
    // Bit-time counts for break generation and detection
    // ------------------------------------------------------------
    localparam logic [3:0] BRK_TX_SHORT = 4'ha;
    localparam logic [3:0] BRK_TX_LONG = 4'hd;
    localparam logic [3:0] BRK_DET_SHORT = 4'ha;
    localparam logic [3:0] BRK_DET_LONG = 4'hb;
    localparam logic [3:0] NINE_BIT_EXTRA = 4'h1;

    // Register port request
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // Events from the receive shifter
    typedef struct packed {
        logic start_det;
        logic idle_det;
        logic char_done;
        logic stop_low;
        logic ninth;
        logic standby;
    } rx_evt_t;

    // Error flags held by the main status register
    typedef struct packed {
        logic overrun;
        logic noise;
        logic frame;
        logic parity;
    } err_flags_t;

    typedef enum logic {BRK_IDLE, BRK_SEND} brk_state_t;

endpackage

// [design/uart_aux_status_control.sv]
// Auxiliary status and control logic of a LIN capable asynchronous serial port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Flag LIN break when detection enabled; w1c
// - Flag active receive edge by polarity; w1c
// - Receive inversion applies to whole frame
// - Standby idle sets idle only if reporting
// - Break length 10/11 or 13/14 bits
// - Framing checks ignore long break setting
// - Break detect at 10/11 or 11/12 lows
// - Break detection inhibits framing and full flags
// - Receiver active on start, cleared at idle
// - Capture ninth received bit in nine-bit mode
// - Data write moves stored ninth bit out
// - Single-wire pin direction from direction bit
// - Transmit inversion drives inverted output level
// - Overrun interrupt when flag and enable
// - Noise interrupt when flag and enable
// - Framing interrupt when flag and enable
// - Parity interrupt when flag and enable
// - Transmit inversion covers every element
// - Framing error with full on low stop
module uart_aux_status_control
    import uart_aux_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    input wire logic rxd_pin,
    input wire logic txd_pin_in,
    output logic txd_pin_out,
    output logic txd_pin_oe,
    input wire logic bit_tick,
    input wire logic word9,
    input wire logic loop_mode_sel,
    input wire logic loop_source_sel,
    input wire rx_evt_t rx_evt,
    input wire err_flags_t err_flags,
    input wire logic tx_serial,
    input wire logic tx_break_req,
    input wire logic data_reg_write,
    output logic rx_line,
    output logic rx_full_set,
    output logic frame_err_set,
    output logic idle_set,
    output logic tx_break_busy,
    output logic tx_ninth_out,
    output logic irq_req
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic rxd_s1;
        logic rxd_s2;
        logic txd_s1;
        logic txd_s2;
        logic line_prev;
        logic line_break_seen_flag;
        logic rx_edge_flag;
        logic rx_polarity_invert;
        logic standby_idle_report;
        logic long_break_tx;
        logic long_break_detect_en;
        logic rx_active_flag;
        logic rx_ninth_bit;
        logic tx_ninth_bit;
        logic single_wire_tx_dir;
        logic tx_polarity_invert;
        logic [3:0] irq_en;
        logic [3:0] low_count;
        brk_state_t brk_state;
        logic [3:0] brk_count;
        logic tx_ninth_shift;
        logic [7:0] rdata;
    } state_t;

    state_t st;
    state_t next_st;
    logic wr_status;
    logic wr_control;
    logic single_wire;
    logic rx_source;
    logic tx_level;
    logic [3:0] det_len;
    logic [3:0] brk_len;
    logic break_hit;

    // Nine-bit words stretch every break length by one bit time
    function automatic logic [3:0] bit_len(input logic nine, input logic [3:0] base);
        bit_len = nine ? base + NINE_BIT_EXTRA : base;
    endfunction

    // ------------------------------------------------------------
    // Line selection and derived terms
    // ------------------------------------------------------------
    assign wr_status = reg_req.wr && reg_req.addr == REG_AUX_STATUS;
    assign wr_control = reg_req.wr && reg_req.addr == REG_AUX_CONTROL;
    assign single_wire = loop_mode_sel && loop_source_sel;
    // Break overrides the shifter; inversion sits last so it covers idle too
    assign tx_level = (st.brk_state == BRK_SEND) ? 1'b0 : tx_serial;
    assign txd_pin_out = tx_level ^ st.tx_polarity_invert;
    assign txd_pin_oe = single_wire ? st.single_wire_tx_dir : 1'b1;
    // Internal loop feeds the uninverted transmit level straight back
    assign rx_source = !loop_mode_sel ? st.rxd_s2 : (loop_source_sel ? st.txd_s2 : tx_level);
    assign rx_line = rx_source ^ st.rx_polarity_invert;
    // Long break transmit is deliberately absent from the detection length
    assign det_len = bit_len(word9, st.long_break_detect_en ? BRK_DET_LONG : BRK_DET_SHORT);
    assign brk_len = bit_len(word9, st.long_break_tx ? BRK_TX_LONG : BRK_TX_SHORT);
    assign break_hit = bit_tick && !rx_line && st.low_count == det_len - 4'h1;

    // Flag gating toward the main status register
    assign rx_full_set = rx_evt.char_done && !st.long_break_detect_en;
    assign frame_err_set = rx_full_set && rx_evt.stop_low;
    assign idle_set = rx_evt.idle_det && (!rx_evt.standby || st.standby_idle_report);
    assign tx_break_busy = st.brk_state == BRK_SEND;
    assign tx_ninth_out = st.tx_ninth_shift;
    assign reg_rdata = st.rdata;
    // Each error flag requests service only when its enable is set
    assign irq_req = (err_flags.overrun && st.irq_en[3])
        || (err_flags.noise && st.irq_en[2])
        || (err_flags.frame && st.irq_en[1])
        || (err_flags.parity && st.irq_en[0]);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Two-stage synchronisers for both pins
        next_st.rxd_s1 = rxd_pin;
        next_st.rxd_s2 = st.rxd_s1;
        next_st.txd_s1 = txd_pin_in;
        next_st.txd_s2 = st.txd_s1;
        next_st.line_prev = rx_line;

        // Consecutive low bit times, saturating at 15, above the longest threshold
        if (bit_tick) begin
            if (rx_line) begin
                next_st.low_count = 4'h0;
            end else if (st.low_count != 4'hf) begin
                next_st.low_count = st.low_count + 4'h1;
            end
        end

        // Sticky flags: a set in the clearing cycle wins
        next_st.line_break_seen_flag = (st.line_break_seen_flag
            && !(wr_status && reg_req.wdata[ST_BREAK_SEEN]))
            || (break_hit && st.long_break_detect_en);
        // Inverted line falls on a falling pin edge, or a rising one when inverted
        next_st.rx_edge_flag = (st.rx_edge_flag && !(wr_status && reg_req.wdata[ST_RX_EDGE]))
            || (st.line_prev && !rx_line);

        // Receiver activity follows start and idle detection
        if (rx_evt.start_det) begin
            next_st.rx_active_flag = 1'b1;
        end else if (rx_evt.idle_det) begin
            next_st.rx_active_flag = 1'b0;
        end

        // Ninth bit only updates with a buffered character
        if (rx_full_set && word9) begin
            next_st.rx_ninth_bit = rx_evt.ninth;
        end
        if (data_reg_write && word9) begin
            next_st.tx_ninth_shift = st.tx_ninth_bit;
        end

        // Break generator counts whole bit times while the line is held low
        case (st.brk_state)
            BRK_IDLE: begin
                if (tx_break_req) begin
                    next_st.brk_state = BRK_SEND;
                    next_st.brk_count = 4'h0;
                end
            end
            BRK_SEND: begin
                if (bit_tick) begin
                    next_st.brk_count = st.brk_count + 4'h1;
                    if (st.brk_count + 4'h1 == brk_len) begin
                        next_st.brk_state = BRK_IDLE;
                    end
                end
            end
            default: begin
                next_st.brk_state = BRK_IDLE;
            end
        endcase

        // Register writes
        if (wr_status) begin
            next_st.rx_polarity_invert = reg_req.wdata[ST_RX_INV];
            next_st.standby_idle_report = reg_req.wdata[ST_IDLE_REPORT];
            next_st.long_break_tx = reg_req.wdata[ST_LONG_BRK_TX];
            next_st.long_break_detect_en = reg_req.wdata[ST_LONG_BRK_DET];
        end
        if (wr_control) begin
            next_st.tx_ninth_bit = reg_req.wdata[CT_TX_NINTH];
            next_st.single_wire_tx_dir = reg_req.wdata[CT_TX_DIR];
            next_st.tx_polarity_invert = reg_req.wdata[CT_TX_INV];
            next_st.irq_en = reg_req.wdata[CT_OVERRUN_IE:CT_PARITY_IE];
        end

        // Read data stands for one cycle only; unmapped reads give zero
        next_st.rdata = 8'h00;
        if (reg_req.rd) begin
            case (reg_req.addr)
                REG_AUX_STATUS: begin
                    next_st.rdata = {st.line_break_seen_flag, st.rx_edge_flag, 1'b0,
                        st.rx_polarity_invert, st.standby_idle_report, st.long_break_tx,
                        st.long_break_detect_en, st.rx_active_flag};
                end
                REG_AUX_CONTROL: begin
                    next_st.rdata = {st.rx_ninth_bit, st.tx_ninth_bit,
                        st.single_wire_tx_dir, st.tx_polarity_invert, st.irq_en};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Pin stages reset high so no false edge appears after release
    always_ff @(posedge clk) begin
        if (reset) begin
            st <= '0;
            st.rxd_s1 <= 1'b1;
            st.rxd_s2 <= 1'b1;
            st.txd_s1 <= 1'b1;
            st.txd_s2 <= 1'b1;
            st.line_prev <= 1'b1;
            st.brk_state <= BRK_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);

    a_break_flag_set: assert property (
        break_hit && st.long_break_detect_en |=> st.line_break_seen_flag)
        else $error("break flag not set on detected break");
    a_break_flag_cause: assert property (
        $rose(st.line_break_seen_flag) |-> $past(st.low_count) == $past(det_len) - 4'h1
            && $past(bit_tick) && !$past(rx_line))
        else $error("break flag rose at wrong low count");
    a_edge_flag_set: assert property (
        $fell(rx_line) |=> st.rx_edge_flag)
        else $error("active edge not flagged");
    a_line_invert: assert property (
        !loop_mode_sel |-> rx_line == (st.rxd_s2 ^ st.rx_polarity_invert))
        else $error("receive line polarity wrong");
    a_idle_gate: assert property (
        rx_evt.standby && !st.standby_idle_report |-> !idle_set)
        else $error("idle reported in standby without enable");
    a_break_length: assert property (
        $fell(tx_break_busy) |-> $past(st.brk_count) + 4'h1 == $past(brk_len))
        else $error("break ended at wrong length");
    a_break_low: assert property (
        tx_break_busy |-> txd_pin_out == st.tx_polarity_invert)
        else $error("break level wrong on pin");
    a_inhibit_full: assert property (
        st.long_break_detect_en |-> !rx_full_set && !frame_err_set)
        else $error("flags set while break detection on");
    a_active_flag: assert property (
        rx_evt.start_det |=> st.rx_active_flag)
        else $error("receiver active not set");
    a_ninth_capture: assert property (
        rx_full_set && word9 |=> st.rx_ninth_bit == $past(rx_evt.ninth))
        else $error("ninth receive bit not captured");
    a_ninth_move: assert property (
        data_reg_write && word9 |=> tx_ninth_out == $past(st.tx_ninth_bit))
        else $error("ninth transmit bit not moved");
    a_pin_dir: assert property (
        single_wire |-> txd_pin_oe == st.single_wire_tx_dir)
        else $error("single wire direction wrong");
    a_irq_overrun: assert property (
        err_flags.overrun && st.irq_en[3] |-> irq_req)
        else $error("overrun interrupt missing");
    a_irq_quiet: assert property (
        st.irq_en == 4'h0 |-> !irq_req)
        else $error("interrupt without enable");
    a_frame_set: assert property (
        rx_evt.char_done && rx_evt.stop_low && !st.long_break_detect_en
            |-> frame_err_set && rx_full_set)
        else $error("framing error not flagged");
    a_irq_noise: assert property (
        err_flags.noise && st.irq_en[2] |-> irq_req)
        else $error("noise interrupt missing");
    a_irq_frame: assert property (
        err_flags.frame && st.irq_en[1] |-> irq_req)
        else $error("framing interrupt missing");
    a_irq_parity: assert property (
        err_flags.parity && st.irq_en[0] |-> irq_req)
        else $error("parity interrupt missing");
    a_edge_cause: assert property (
        $rose(st.rx_edge_flag) |-> $past(st.line_prev) && !$past(rx_line))
        else $error("edge flag rose without active edge");
    a_break_hold: assert property (
        st.line_break_seen_flag && !(wr_status && reg_req.wdata[ST_BREAK_SEEN])
            |=> st.line_break_seen_flag)
        else $error("break flag lost without clear");
    a_break_gated: assert property (
        !st.long_break_detect_en |=> !$rose(st.line_break_seen_flag))
        else $error("break flag set while detection off");
    a_active_clear: assert property (
        rx_evt.idle_det && !rx_evt.start_det |=> !st.rx_active_flag)
        else $error("receiver active not cleared at idle");
    a_idle_pass: assert property (
        rx_evt.idle_det && !rx_evt.standby |-> idle_set)
        else $error("idle outside standby not reported");
    a_break_start: assert property (
        tx_break_req && !tx_break_busy |=> tx_break_busy)
        else $error("break request not started");
    a_tx_invert: assert property (
        !tx_break_busy |-> txd_pin_out == (tx_serial ^ st.tx_polarity_invert))
        else $error("transmit pin polarity wrong");
    a_oe_default: assert property (
        !single_wire |-> txd_pin_oe)
        else $error("transmit pin released outside single wire");
    a_ninth_hold: assert property (
        !(rx_full_set && word9) |=> $stable(st.rx_ninth_bit))
        else $error("ninth receive bit changed without character");

    c_break_seen: cover property ($rose(st.line_break_seen_flag));
    c_long_break_tx: cover property ($fell(tx_break_busy) && st.long_break_tx && word9);
    c_edge_clear_race: cover property (wr_status && reg_req.wdata[ST_RX_EDGE] && $fell(rx_line));
    c_irq: cover property ($rose(irq_req));
    c_ninth_move: cover property (data_reg_write && word9 && st.tx_ninth_bit);

endmodule

`default_nettype wire

// [sim/uart_node_model.sv]
// Remote serial node model that drives low stretches onto the receive pin
`timescale 1ns/100ps
`default_nettype none
module uart_node_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic bit_tick,
    input wire logic send,
    input wire logic [3:0] low_bits,
    output logic rxd,
    output logic busy
);
    logic [3:0] left;
    logic pending;
    // ----------------------------------------
    // Line driver
    // ----------------------------------------
    // Idle is high; a stretch starts and ends on bit boundaries, so every low bit is whole
    always_ff @(posedge clk) begin
        if (reset) begin
            rxd <= 1'b1;
            left <= 4'h0;
            pending <= 1'b0;
        end else if (bit_tick && pending) begin
            rxd <= 1'b0;
            left <= low_bits;
            pending <= 1'b0;
        end else begin
            if (send) begin
                pending <= 1'b1;
            end
            if (bit_tick && left != 4'h0) begin
                left <= left - 4'h1;
                rxd <= (left == 4'h1);
            end
        end
    end
    assign busy = pending || (left != 4'h0);
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the serial port auxiliary status and control block
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import uart_aux_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    reg_req_t reg_req = '0;
    rx_evt_t rx_evt = '0;
    err_flags_t err_flags = '0;
    logic bit_tick = 1'b0;
    logic word9 = 1'b0;
    logic loop_mode_sel = 1'b0;
    logic loop_source_sel = 1'b0;
    logic tx_serial = 1'b1;
    logic tx_break_req = 1'b0;
    logic data_reg_write = 1'b0;
    logic send = 1'b0;
    logic [3:0] low_bits = 4'h0;
    logic [1:0] tick_div = 2'h0;
    logic [7:0] reg_rdata, rd;
    logic rxd_pin, txd_pin_out, txd_pin_oe, rx_line, rx_full_set, frame_err_set;
    logic idle_set, tx_break_busy, tx_ninth_out, irq_req, node_busy;
    wire txd_pin_in = txd_pin_oe ? txd_pin_out : 1'b1;
    int num_errors = 0;
    int num_checks = 0;
    // ----------------------------------------
    // Clock, bit time and instances
    // ----------------------------------------
    always #12.5 clk = ~clk;
    // Four clocks per bit keeps long breaks short in simulation time
    always @(posedge clk) begin
        tick_div <= tick_div + 2'h1;
        bit_tick <= (tick_div == 2'h3);
    end
    uart_aux_status_control i_uart_aux_status_control (.clk(clk), .reset(reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
        .txd_pin_in(txd_pin_in), .txd_pin_out(txd_pin_out), .txd_pin_oe(txd_pin_oe),
        .bit_tick(bit_tick), .word9(word9), .loop_mode_sel(loop_mode_sel),
        .loop_source_sel(loop_source_sel), .rx_evt(rx_evt), .err_flags(err_flags),
        .tx_serial(tx_serial), .tx_break_req(tx_break_req),
        .data_reg_write(data_reg_write), .rx_line(rx_line), .rx_full_set(rx_full_set),
        .frame_err_set(frame_err_set), .idle_set(idle_set),
        .tx_break_busy(tx_break_busy), .tx_ninth_out(tx_ninth_out), .irq_req(irq_req));
    uart_node_model i_uart_node_model (.clk(clk), .reset(reset), .bit_tick(bit_tick),
        .send(send), .low_bits(low_bits), .rxd(rxd_pin), .busy(node_busy));
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input string w, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", w, e, g);
        end
    endtask
    task automatic reg_wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [1:0] a);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(negedge clk);
        rd = reg_rdata;
    endtask
    task automatic start_low(input int n);
        @(posedge clk);
        low_bits <= 4'(n);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
    endtask
    // Idle high ticks afterwards reset the receiver's low count
    task automatic wait_node();
        @(negedge clk);
        for (int k = 0; k < 200 && node_busy; k++) @(negedge clk);
        repeat (12) @(posedge clk);
        if (node_busy) begin
            num_errors++;
            complete_run();
        end
    endtask
    function automatic int brk_tx_len(input logic lng, input logic w9);
        return (lng ? 13 : 10) + int'(w9);
    endfunction
    function automatic int brk_det_len(input logic en, input logic w9);
        return (en ? 11 : 10) + int'(w9);
    endfunction
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        int i, n;
        logic [7:0] d;
        logic [3:0] f;
        void'($urandom(1700));
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        reg_rd(REG_AUX_STATUS);
        check("status reset", 8'h00, rd);
        reg_rd(REG_AUX_CONTROL);
        check("control reset", 8'h00, rd);
        reg_wr(2'h2, 8'hff);
        reg_rd(2'h2);
        check("unmapped", 8'h00, rd);
        // Random enables, flags, polarity and loop setup
        for (i = 0; i < 16; i++) begin
            d = 8'($urandom);
            f = 4'($urandom);
            reg_wr(REG_AUX_CONTROL, d);
            err_flags <= f;
            tx_serial <= d[7];
            {loop_mode_sel, loop_source_sel} <= 2'(i);
            @(negedge clk);
            check("irq", {7'h0, |(f & d[3:0])}, {7'h0, irq_req});
            check("txd level", {7'h0, d[7] ^ d[4]}, {7'h0, txd_pin_out});
            check("txd oe", {7'h0, (i % 4 == 3) ? d[5] : 1'b1}, {7'h0, txd_pin_oe});
            reg_rd(REG_AUX_CONTROL);
            check("control", {1'b0, d[6:0]}, rd);
        end
        @(posedge clk);
        {loop_mode_sel, loop_source_sel, tx_serial, err_flags} <= 7'h10;
        reg_wr(REG_AUX_CONTROL, 8'h00);
        reg_wr(REG_AUX_STATUS, 8'hc0);
        // Active edge flag and receive inversion
        start_low(2);
        wait_node();
        reg_rd(REG_AUX_STATUS);
        check("edge plain", 8'h40, rd);
        reg_wr(REG_AUX_STATUS, 8'h50);
        @(negedge clk);
        check("rx line inv", 8'h00, {7'h0, rx_line});
        reg_wr(REG_AUX_STATUS, 8'h50);
        start_low(3);
        repeat (6) @(posedge clk);
        reg_rd(REG_AUX_STATUS);
        check("edge falling inv", 8'h10, rd);
        wait_node();
        reg_rd(REG_AUX_STATUS);
        check("edge rising inv", 8'h50, rd);
        reg_wr(REG_AUX_STATUS, 8'h40);
        reg_rd(REG_AUX_STATUS);
        check("edge cleared", 8'h00, rd);
        // Break generation for every length setting
        for (i = 0; i < 4; i++) begin
            reg_wr(REG_AUX_STATUS, {5'h0, i[1], 2'h0});
            reg_wr(REG_AUX_CONTROL, {3'h0, i[0], 4'h0});
            word9 <= i[0];
            for (int k = 0; k < 4 && tick_div != 2'h1; k++) @(posedge clk);
            tx_break_req <= 1'b1;
            @(posedge clk);
            tx_break_req <= 1'b0;
            n = 0;
            @(negedge clk);
            check("break pin", {7'h0, i[0]}, {7'h0, txd_pin_out});
            for (int k = 0; k < 400 && tx_break_busy === 1'b1; k++) begin
                if (bit_tick === 1'b1) n++;
                @(negedge clk);
            end
            check("break len", 8'(brk_tx_len(i[1], i[0])), 8'(n));
        end
        reg_wr(REG_AUX_CONTROL, 8'h00);
        // Break detection just under and at the threshold
        for (i = 0; i < 4; i++) begin
            @(posedge clk);
            word9 <= i[0];
            reg_wr(REG_AUX_STATUS, {6'h0, i[1], 1'b0});
            n = brk_det_len(i[1], i[0]);
            start_low(n - 1);
            wait_node();
            reg_rd(REG_AUX_STATUS);
            check("break short", 8'h00, rd & 8'h80);
            start_low(n);
            wait_node();
            reg_rd(REG_AUX_STATUS);
            check("break seen", {i[1], 7'h0}, rd & 8'h80);
            reg_wr(REG_AUX_STATUS, 8'hc0);
            reg_rd(REG_AUX_STATUS);
            check("break clear", 8'h00, rd & 8'h80);
        end
        // Random shifter events against gating settings
        for (i = 0; i < 16; i++) begin
            d = 8'($urandom);
            reg_wr(REG_AUX_STATUS, {4'h0, d[0], d[5], d[1], 1'b0});
            rx_evt <= {1'b0, d[2], d[3], d[4], 1'b0, d[6]};
            @(negedge clk);
            check("full set", {7'h0, d[3] & !d[1]}, {7'h0, rx_full_set});
            check("frame set", {7'h0, d[3] & !d[1] & d[4]}, {7'h0, frame_err_set});
            check("idle set", {7'h0, d[2] & (!d[6] | d[0])}, {7'h0, idle_set});
            @(posedge clk);
            rx_evt <= '0;
        end
        // Receiver active flag and ninth bits
        word9 <= 1'b1;
        reg_wr(REG_AUX_STATUS, 8'hc0);
        rx_evt.start_det <= 1'b1;
        @(posedge clk);
        rx_evt.start_det <= 1'b0;
        reg_rd(REG_AUX_STATUS);
        check("rx active", 8'h01, rd & 8'h01);
        @(posedge clk);
        rx_evt <= 6'b011010;
        @(posedge clk);
        rx_evt <= '0;
        reg_rd(REG_AUX_CONTROL);
        check("rx ninth", 8'h80, rd);
        reg_rd(REG_AUX_STATUS);
        check("rx idle", 8'h00, rd & 8'h01);
        for (i = 0; i < 3; i++) begin
            reg_wr(REG_AUX_CONTROL, (i == 0) ? 8'h40 : 8'h00);
            data_reg_write <= (i != 1);
            @(posedge clk);
            data_reg_write <= 1'b0;
            @(negedge clk);
            check("tx ninth", {7'h0, i < 2}, {7'h0, tx_ninth_out});
        end
        complete_run();
    end
endmodule
`default_nettype wire
